// >>> mcsfr_core_regs.sv
// Core special-function register set of the 8-bit controller
// Contract
// - Registers lie within the top 128 data addresses, reached only directly.
// - Every core register but fetch counter, opcode holder, banks is here.
// - Only flags, working and multiply operand registers take bit access.
// - Flags bit 7 is carry, updated by all five arithmetic operations.
// - Flags bit 6 is half carry, updated only by the two add operations.
// - Flags bits 5 and 1 are free user flags with no hardware effect.
// - Flags bits 4:3 select register bank 0 to 3 by their binary value.
// - Flags bit 2 is signed overflow, updated like the carry.
// - Flags bit 0 keeps even parity over the working register plus itself.
// - Baud control bit 7 doubles the baud rate and resets to zero.
// - The 16-bit memory pointer is high byte 0x83 joined to low byte 0x82.
// - Both pointer bytes hold eight bits and clear on reset.
// - The stack register holds the stack address low byte, reset to 7.
// - A non bit-addressable setup byte sits at 0xAF.
`default_nettype none

module mcsfr_core_regs
    import mcsfr_pkg::*;
(
    input  wire logic                    I_CLOCK,
    input  wire logic                    I_NRST,
    input  wire mcsfr_pkg::mcsfr_dir_req_t  I_DIR,
    input  wire mcsfr_pkg::mcsfr_bit_req_t  I_BIT,
    input  wire mcsfr_pkg::mcsfr_flag_upd_t I_FLAG_UPD,
    input  wire logic                    I_WORK_LD,
    input  wire logic [7:0]              I_WORK_VAL,
    input  wire logic                    I_MULOP_LD,
    input  wire logic [7:0]              I_MULOP_VAL,
    input  wire logic                    I_PTR_LD,
    input  wire logic [15:0]             I_PTR_VAL,
    input  wire logic                    I_STACK_LD,
    input  wire logic [7:0]              I_STACK_VAL,
    output logic [7:0]                   O_RDATA,
    output logic                         O_RD_ACK,
    output logic                         O_BIT_RDATA,
    output logic                         O_BIT_ACK,
    output logic [7:0]                   O_WORK,
    output logic [7:0]                   O_MULOP,
    output logic [7:0]                   O_FLAGS,
    output logic [1:0]                   O_BANK,
    output logic [15:0]                  O_PTR,
    output logic [7:0]                   O_STACK,
    output logic                         O_BAUD_DOUBLER,
    output logic [7:0]                   O_SETUP
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] stack_top_index;
    logic [7:0] pointer_low_byte;
    logic [7:0] pointer_high_byte;
    logic [7:0] baud_control_word;
    logic [7:0] system_setup_byte;
    logic [7:0] processor_flags_word;
    logic [7:0] working_register;
    logic [7:0] multiply_operand_register;
    logic [7:0] rdata;
    logic       rd_ack;
    logic       bit_rdata;
    logic       bit_ack;

    // ************************************************************
    // Decode
    // ************************************************************
    mcsfr_sel_t dsel;
    mcsfr_sel_t bsel;
    logic       dhit;
    logic       bhit_any;
    logic       bhit;

    mcsfr_decode u_dir_decode (
        .i_addr     (I_DIR.addr),
        .i_indirect (I_DIR.indirect),
        .o_sel      (dsel),
        .o_hit      (dhit),
        .o_bitable  ()
    );

    // Bit accesses are always direct by nature
    mcsfr_decode u_bit_decode (
        .i_addr     (bit_owner(I_BIT.addr)),
        .i_indirect (1'b0),
        .o_sel      (bsel),
        .o_hit      (bhit_any),
        .o_bitable  (bhit)
    );

    wire [2:0] bidx = I_BIT.addr[BIT_IDX_W-1:0];
    wire       bwr  = I_BIT.wr && bhit;
    wire       brd  = I_BIT.rd && bhit;
    wire       dwr  = I_DIR.wr && dhit;
    wire       drd  = I_DIR.rd && dhit;

    // ************************************************************
    // Next values
    // ************************************************************
    wire [7:0] next_stack_top_index =
        I_STACK_LD                ? I_STACK_VAL :
        (dwr && dsel.stack)       ? I_DIR.wdata : stack_top_index;

    // Pointer loads as one 16-bit value or as two bytes
    wire [7:0] next_pointer_low_byte =
        I_PTR_LD                  ? I_PTR_VAL[7:0] :
        (dwr && dsel.ptr_lo)      ? I_DIR.wdata : pointer_low_byte;
    wire [7:0] next_pointer_high_byte =
        I_PTR_LD                  ? I_PTR_VAL[15:8] :
        (dwr && dsel.ptr_hi)      ? I_DIR.wdata : pointer_high_byte;

    // Low bits kept as written; software must leave them zero
    wire [7:0] next_baud_control_word =
        (dwr && dsel.baud)        ? I_DIR.wdata : baud_control_word;

    wire [7:0] next_system_setup_byte =
        (dwr && dsel.setup)       ? I_DIR.wdata : system_setup_byte;

    wire [7:0] next_working_register =
        I_WORK_LD                 ? I_WORK_VAL :
        (dwr && dsel.work)        ? I_DIR.wdata :
        (bwr && bsel.work)        ? put_bit(working_register, bidx,
                                            I_BIT.wbit) :
                                    working_register;

    wire [7:0] next_multiply_operand_register =
        I_MULOP_LD                ? I_MULOP_VAL :
        (dwr && dsel.mulop)       ? I_DIR.wdata :
        (bwr && bsel.mulop)       ? put_bit(multiply_operand_register,
                                            bidx, I_BIT.wbit) :
                                    multiply_operand_register;

    // Software view of the flags; hardware flag updates override it
    wire [7:0] sw_flags =
        (dwr && dsel.flags)       ? I_DIR.wdata :
        (bwr && bsel.flags)       ? put_bit(processor_flags_word, bidx,
                                            I_BIT.wbit) :
                                    processor_flags_word;

    logic [7:0] next_processor_flags_word;

    mcsfr_flags u_flags (
        .i_base  (sw_flags),
        .i_upd   (I_FLAG_UPD),
        .i_work  (next_working_register),
        .o_flags (next_processor_flags_word)
    );

    // ************************************************************
    // Read selection
    // ************************************************************
    wire [7:0] dir_mux =
          ({8{dsel.stack}}  & stack_top_index)
        | ({8{dsel.ptr_lo}} & pointer_low_byte)
        | ({8{dsel.ptr_hi}} & pointer_high_byte)
        | ({8{dsel.baud}}   & baud_control_word)
        | ({8{dsel.setup}}  & system_setup_byte)
        | ({8{dsel.flags}}  & processor_flags_word)
        | ({8{dsel.work}}   & working_register)
        | ({8{dsel.mulop}}  & multiply_operand_register);

    wire [7:0] bit_byte =
          ({8{bsel.flags}}  & processor_flags_word)
        | ({8{bsel.work}}   & working_register)
        | ({8{bsel.mulop}}  & multiply_operand_register);

    wire [7:0] next_rdata     = drd ? dir_mux : RD_NONE;
    wire       next_bit_rdata = brd && bit_byte[bidx];

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            stack_top_index           <= RST_STACK;
            pointer_low_byte          <= RST_PTR_LO;
            pointer_high_byte         <= RST_PTR_HI;
            baud_control_word         <= RST_BAUD;
            system_setup_byte         <= RST_SETUP;
            processor_flags_word      <= RST_FLAGS;
            working_register          <= RST_WORK;
            multiply_operand_register <= RST_MULOP;
        end else begin
            stack_top_index           <= next_stack_top_index;
            pointer_low_byte          <= next_pointer_low_byte;
            pointer_high_byte         <= next_pointer_high_byte;
            baud_control_word         <= next_baud_control_word;
            system_setup_byte         <= next_system_setup_byte;
            processor_flags_word      <= next_processor_flags_word;
            working_register          <= next_working_register;
            multiply_operand_register <= next_multiply_operand_register;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            rdata     <= RD_NONE;
            rd_ack    <= 1'b0;
            bit_rdata <= 1'b0;
            bit_ack   <= 1'b0;
        end else begin
            rdata     <= next_rdata;
            rd_ack    <= drd;
            bit_rdata <= next_bit_rdata;
            bit_ack   <= brd;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign O_RDATA        = rdata;
    assign O_RD_ACK       = rd_ack;
    assign O_BIT_RDATA    = bit_rdata;
    assign O_BIT_ACK      = bit_ack;
    assign O_WORK         = working_register;
    assign O_MULOP        = multiply_operand_register;
    assign O_FLAGS        = processor_flags_word;
    assign O_BANK         = processor_flags_word[FLG_BANK_H:FLG_BANK_L];
    assign O_PTR          = {pointer_high_byte, pointer_low_byte};
    assign O_STACK        = stack_top_index;
    assign O_BAUD_DOUBLER = baud_control_word[BAUD_DBL];
    assign O_SETUP        = system_setup_byte;

    // Fetch counter, opcode holder and banks stay in the core proper
    wire unused_ok = bhit_any;
endmodule // mcsfr_core_regs

`default_nettype wire

// >>> mcsfr_pkg.sv
// Constants and types shared by the core register set
`default_nettype none

package mcsfr_pkg;

    // ************************************************************
    // Widths and address map
    // ************************************************************
    localparam int         DATA_W       = 8;
    localparam int         PTR_W        = 16;
    localparam int         BIT_IDX_W    = 3;
    localparam logic [7:0] SFR_BASE     = 8'h80;
    localparam logic [7:0] ADDR_STACK   = 8'h81;
    localparam logic [7:0] ADDR_PTR_LO  = 8'h82;
    localparam logic [7:0] ADDR_PTR_HI  = 8'h83;
    localparam logic [7:0] ADDR_BAUD    = 8'h87;
    localparam logic [7:0] ADDR_SETUP   = 8'hAF;
    localparam logic [7:0] ADDR_FLAGS   = 8'hD0;
    localparam logic [7:0] ADDR_WORK    = 8'hE0;
    localparam logic [7:0] ADDR_MULOP   = 8'hF0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_STACK    = 8'h07;
    localparam logic [7:0] RST_PTR_LO   = 8'h00;
    localparam logic [7:0] RST_PTR_HI   = 8'h00;
    localparam logic [7:0] RST_BAUD     = 8'h00;
    localparam logic [7:0] RST_SETUP    = 8'h81;
    localparam logic [7:0] RST_FLAGS    = 8'h00;
    localparam logic [7:0] RST_WORK     = 8'h00;
    localparam logic [7:0] RST_MULOP    = 8'h00;
    localparam logic [7:0] RD_NONE      = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int FLG_CARRY  = 7;
    localparam int FLG_HALF   = 6;
    localparam int FLG_USER0  = 5;
    localparam int FLG_BANK_H = 4;
    localparam int FLG_BANK_L = 3;
    localparam int FLG_OVF    = 2;
    localparam int FLG_USER1  = 1;
    localparam int FLG_PARITY = 0;
    localparam int BAUD_DBL   = 7;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        MCSFR_OP_NONE = 3'h0,
        MCSFR_OP_ADD  = 3'h1,
        MCSFR_OP_ADDC = 3'h2,
        MCSFR_OP_SUBB = 3'h3,
        MCSFR_OP_MUL  = 3'h4,
        MCSFR_OP_DIV  = 3'h5
    } mcsfr_op_t;

    typedef struct packed {
        mcsfr_op_t op;
        logic      carry;
        logic      half;
        logic      ovf;
    } mcsfr_flag_upd_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic       indirect;
        logic [7:0] wdata;
    } mcsfr_dir_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic       wbit;
    } mcsfr_bit_req_t;

    typedef struct packed {
        logic stack;
        logic ptr_lo;
        logic ptr_hi;
        logic baud;
        logic setup;
        logic flags;
        logic work;
        logic mulop;
    } mcsfr_sel_t;

    // Byte address that owns a bit address
    function automatic logic [7:0] bit_owner(input logic [7:0] baddr);
        return {baddr[7:BIT_IDX_W], {BIT_IDX_W{1'b0}}};
    endfunction

    // Replace one bit of a byte
    function automatic logic [7:0] put_bit(input logic [7:0] v,
                                           input logic [2:0] idx,
                                           input logic       b);
        logic [7:0] r;
        r      = v;
        r[idx] = b;
        return r;
    endfunction

endpackage

`default_nettype wire

// >>> mcsfr_decode.sv
// Address decoder for the core register set
`default_nettype none

module mcsfr_decode
    import mcsfr_pkg::*;
(
    input  wire logic [7:0] i_addr,
    input  wire logic       i_indirect,
    output mcsfr_sel_t      o_sel,
    output logic            o_hit,
    output logic            o_bitable
);
    // Indirect accesses to the upper half reach RAM, never these registers
    wire upper = (i_addr >= SFR_BASE) && !i_indirect;

    assign o_sel.stack  = upper && (i_addr == ADDR_STACK);
    assign o_sel.ptr_lo = upper && (i_addr == ADDR_PTR_LO);
    assign o_sel.ptr_hi = upper && (i_addr == ADDR_PTR_HI);
    assign o_sel.baud   = upper && (i_addr == ADDR_BAUD);
    assign o_sel.setup  = upper && (i_addr == ADDR_SETUP);
    assign o_sel.flags  = upper && (i_addr == ADDR_FLAGS);
    assign o_sel.work   = upper && (i_addr == ADDR_WORK);
    assign o_sel.mulop  = upper && (i_addr == ADDR_MULOP);

    assign o_hit     = |o_sel;
    assign o_bitable = o_sel.flags | o_sel.work | o_sel.mulop;
endmodule // mcsfr_decode

`default_nettype wire

// >>> mcsfr_flags.sv
// Hardware update of the processor flags word
`default_nettype none

module mcsfr_flags
    import mcsfr_pkg::*;
(
    input  wire logic [7:0]      i_base,
    input  wire mcsfr_flag_upd_t i_upd,
    input  wire logic [7:0]      i_work,
    output logic [7:0]           o_flags
);
    wire arith = (i_upd.op == MCSFR_OP_ADD)  || (i_upd.op == MCSFR_OP_ADDC)
              || (i_upd.op == MCSFR_OP_SUBB) || (i_upd.op == MCSFR_OP_MUL)
              || (i_upd.op == MCSFR_OP_DIV);
    wire adds  = (i_upd.op == MCSFR_OP_ADD)  || (i_upd.op == MCSFR_OP_ADDC);

    wire cy = arith ? i_upd.carry : i_base[FLG_CARRY];
    wire ac = adds  ? i_upd.half  : i_base[FLG_HALF];
    wire ov = arith ? i_upd.ovf   : i_base[FLG_OVF];
    // Even parity over working register plus this bit
    wire par = ^i_work;

    assign o_flags = {cy, ac, i_base[FLG_USER0], i_base[FLG_BANK_H],
                      i_base[FLG_BANK_L], ov, i_base[FLG_USER1], par};
endmodule // mcsfr_flags

`default_nettype wire

// >>> mcsfr_monitor.sv
// Port-level checker for the core register set
`default_nettype none

module mcsfr_monitor (
    input wire logic                       I_CLOCK,
    input wire logic                       I_NRST,
    input wire mcsfr_pkg::mcsfr_dir_req_t  I_DIR,
    input wire mcsfr_pkg::mcsfr_bit_req_t  I_BIT,
    input wire mcsfr_pkg::mcsfr_flag_upd_t I_FLAG_UPD,
    input wire logic                       I_PTR_LD,
    input wire logic [15:0]                I_PTR_VAL,
    input wire logic                       I_STACK_LD,
    input wire logic [7:0]                 I_STACK_VAL,
    input wire logic [7:0]                 O_RDATA,
    input wire logic                       O_RD_ACK,
    input wire logic                       O_BIT_ACK,
    input wire logic [7:0]                 O_WORK,
    input wire logic [7:0]                 O_FLAGS,
    input wire logic [1:0]                 O_BANK,
    input wire logic [15:0]                O_PTR,
    input wire logic [7:0]                 O_STACK,
    input wire logic                       O_BAUD_DOUBLER
);
    timeunit 1ns;
    timeprecision 1ps;
    import mcsfr_pkg::*;
    // ************************************************************
    // Decode and sequences
    // ************************************************************
    wire dir_hit = !I_DIR.indirect && (I_DIR.addr inside {ADDR_STACK,
        ADDR_PTR_LO, ADDR_PTR_HI, ADDR_BAUD, ADDR_SETUP, ADDR_FLAGS,
        ADDR_WORK, ADDR_MULOP});
    wire bit_hit = I_BIT.addr[7:3] inside {5'h1A, 5'h1C, 5'h1E};
    wire no_sw_wr = !I_DIR.wr && !I_BIT.wr;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_NRST);
    sequence s_rd_hit; I_DIR.rd && dir_hit; endsequence
    sequence s_ack_pulse; O_RD_ACK; endsequence
    // ************************************************************
    // Assertions
    // ************************************************************
    a_read_ack: assert property (s_rd_hit |=> s_ack_pulse)
        else $error("hit read not acknowledged");
    a_read_refused: assert property (I_DIR.rd && !dir_hit |=>
        !O_RD_ACK) else $error("refused read acknowledged");
    a_rdata_idle: assert property (!O_RD_ACK |-> O_RDATA == 8'h00)
        else $error("read data not idle");
    a_bit_ack: assert property (I_BIT.rd |=>
        O_BIT_ACK == $past(bit_hit)) else $error("bit ack wrong");
    a_parity_even: assert property (!(^{O_WORK, O_FLAGS[0]}))
        else $error("parity odd");
    a_bank_field: assert property (O_BANK == O_FLAGS[4:3])
        else $error("bank select mismatch");
    a_arith_flags: assert property (
        I_FLAG_UPD.op != MCSFR_OP_NONE
        |=> O_FLAGS[7] == $past(I_FLAG_UPD.carry)
        && O_FLAGS[2] == $past(I_FLAG_UPD.ovf))
        else $error("carry or overflow not updated");
    a_half_kept: assert property (no_sw_wr && I_FLAG_UPD.op inside
        {MCSFR_OP_SUBB, MCSFR_OP_MUL, MCSFR_OP_DIV}
        |=> $stable(O_FLAGS[6])) else $error("half carry changed");
    a_ptr_load: assert property (I_PTR_LD |=>
        O_PTR == $past(I_PTR_VAL)) else $error("pointer load lost");
    a_stack_load: assert property (I_STACK_LD |=>
        O_STACK == $past(I_STACK_VAL)) else $error("stack load lost");
    a_reset_vals: assert property (disable iff (1'b0)
        !I_NRST |=> O_STACK == 8'h07 && O_PTR == 16'h0000
        && !O_BAUD_DOUBLER) else $error("reset values wrong");
endmodule // mcsfr_monitor

bind mcsfr_core_regs mcsfr_monitor u_mon (
    .I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_DIR(I_DIR), .I_BIT(I_BIT),
    .I_FLAG_UPD(I_FLAG_UPD), .I_PTR_LD(I_PTR_LD), .I_PTR_VAL(I_PTR_VAL),
    .I_STACK_LD(I_STACK_LD), .I_STACK_VAL(I_STACK_VAL),
    .O_RDATA(O_RDATA), .O_RD_ACK(O_RD_ACK), .O_BIT_ACK(O_BIT_ACK),
    .O_WORK(O_WORK), .O_FLAGS(O_FLAGS), .O_BANK(O_BANK), .O_PTR(O_PTR),
    .O_STACK(O_STACK), .O_BAUD_DOUBLER(O_BAUD_DOUBLER));

`default_nettype wire

// >>> mcu_core_sfr_registers_test.sv
// Self-checking testbench for the core register set
`default_nettype none

module mcu_core_sfr_registers_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mcsfr_pkg::*;
    localparam logic [7:0] RA [8] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'hAF,
                                      8'hD0, 8'hE0, 8'hF0};
    localparam logic [7:0] RE [8] = '{8'h07, 8'h00, 8'h00, 8'h00,
                                      RST_SETUP, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] TA [4] = '{8'hD5, 8'hD1, 8'hE3, 8'hF6};
    // ************************************************************
    // Signals and design
    // ************************************************************
    logic            clk, nrst, rd_ack, bit_rdata, bit_ack, baud_dbl;
    mcsfr_dir_req_t  dir;
    mcsfr_bit_req_t  bitq;
    mcsfr_flag_upd_t upd;
    logic            work_ld, mulop_ld, ptr_ld, stack_ld;
    logic [7:0]      work_val, mulop_val, stack_val, rdata, work, mulop;
    logic [7:0]      flags, stack, setup;
    logic [15:0]     ptr_val, ptr;
    logic [1:0]      bank;
    int              n_errors, cmp_count;

    mcsfr_core_regs dut (
        .I_CLOCK(clk), .I_NRST(nrst), .I_DIR(dir), .I_BIT(bitq),
        .I_FLAG_UPD(upd), .I_WORK_LD(work_ld), .I_WORK_VAL(work_val),
        .I_MULOP_LD(mulop_ld), .I_MULOP_VAL(mulop_val), .I_PTR_LD(ptr_ld),
        .I_PTR_VAL(ptr_val), .I_STACK_LD(stack_ld),
        .I_STACK_VAL(stack_val), .O_RDATA(rdata), .O_RD_ACK(rd_ack),
        .O_BIT_RDATA(bit_rdata), .O_BIT_ACK(bit_ack), .O_WORK(work),
        .O_MULOP(mulop), .O_FLAGS(flags), .O_BANK(bank), .O_PTR(ptr),
        .O_STACK(stack), .O_BAUD_DOUBLER(baud_dbl), .O_SETUP(setup));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ************************************************************
    // Bus tasks and expectations
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One request per call; an idle cycle separates calls
    task automatic acc(input logic [7:0] a, input logic w, input logic ind,
                       input logic [7:0] d, output logic [8:0] r);
        @(negedge clk);
        dir = '{a, w, !w, ind, d};
        @(negedge clk);
        r = {rd_ack, rdata};
        dir = '0;
    endtask
    task automatic bop(input logic [7:0] a, input logic w, input logic b,
                       output logic [1:0] r);
        @(negedge clk);
        bitq = '{a, w, !w, b};
        @(negedge clk);
        r = {bit_ack, bit_rdata};
        bitq = '0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] r;
        acc(a, 1'b0, 1'b0, 8'h00, r);
        chk(16'(r), {7'h00, 1'b1, e});
    endtask
    task automatic reset_dut();
        @(negedge clk);
        nrst = 1'b0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        chk(ptr, 16'h0000);
        chk(16'(stack), 16'h0007);
        chk(16'(setup), 16'(RST_SETUP));
        foreach (RA[i]) rdchk(RA[i], RE[i]);
    endtask
    function automatic logic [7:0] cur(input logic [7:0] a);
        return (a[7:3] == 5'h1A) ? flags : (a[7:3] == 5'h1C) ? work : mulop;
    endfunction
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [8:0]  r;
        logic [1:0]  br;
        logic [7:0]  a, d, lo, hi, f0;
        logic [15:0] v;
        logic        b, bd;
        nrst = 1'b0; dir = '0; bitq = '0; upd = '0;
        {work_ld, mulop_ld, ptr_ld, stack_ld} = 4'h0;
        {work_val, mulop_val, stack_val, ptr_val} = '0;
        n_errors = 0; cmp_count = 0;
        void'($urandom(83368));
        reset_dut();
        {lo, hi} = 16'h0000;
        bd = 1'b0;
        for (int i = 0; i < 24; i++) begin
            a = RA[$urandom_range(0, 7)];
            d = 8'($urandom);
            if (a == ADDR_BAUD) d = {d[7], 7'h00};
            if (a == ADDR_FLAGS) continue;
            acc(a, 1'b1, 1'b0, d, r);
            if (a == ADDR_PTR_LO) lo = d;
            if (a == ADDR_PTR_HI) hi = d;
            if (a == ADDR_BAUD) bd = d[7];
            rdchk(a, d);
            chk(ptr, {hi, lo});
            chk(16'(baud_dbl), 16'(bd));
            chk(16'(^{work, flags[0]}), 16'h0000);
        end
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            d[4:3] = 2'(k);
            acc(ADDR_FLAGS, 1'b1, 1'b0, d, r);
            chk(16'(bank), 16'(k));
            rdchk(ADDR_FLAGS, {d[7:1], ^work});
        end
        for (int i = 0; i < 8; i++) begin
            a = TA[i % 4];
            b = 1'($urandom);
            bop(a, 1'b1, b, br);
            d = cur(a);
            chk(16'(d[a[2:0]]), 16'(b));
            bop(a, 1'b0, 1'b0, br);
            chk(16'(br), {14'h0000, 1'b1, b});
        end
        foreach (RA[i]) begin
            bop(RA[i] | 8'h07, 1'b0, 1'b0, br);
            chk(16'(br[1]), 16'(RA[i] inside {ADDR_FLAGS, ADDR_WORK,
                ADDR_MULOP}));
        end
        d = work;
        acc(ADDR_WORK, 1'b1, 1'b1, ~d, r);
        chk(16'(work), 16'(d));
        foreach (RE[i]) begin
            acc(i[0] ? ADDR_WORK : 8'(i * 16 + 5), 1'b0, i[0], 8'h00, r);
            chk(16'(r), 16'h0000);
        end
        for (int i = 0; i < 12; i++) begin
            f0 = flags;
            @(negedge clk);
            upd = '{mcsfr_op_t'(i % 5 + 1), 1'($urandom), 1'($urandom),
                    1'($urandom)};
            @(negedge clk);
            chk(16'(flags[7]), 16'(upd.carry));
            chk(16'(flags[2]), 16'(upd.ovf));
            chk(16'(flags[6]), 16'(upd.op inside {MCSFR_OP_ADD,
                MCSFR_OP_ADDC} ? upd.half : f0[6]));
            chk(16'({flags[5], flags[1]}), 16'({f0[5], f0[1]}));
            upd = '0;
        end
        for (int i = 0; i < 6; i++) begin
            v = 16'($urandom);
            @(negedge clk);
            {ptr_val, stack_val, work_val, mulop_val} = {v, v[7:0], v[15:8],
                                                         ~v[7:0]};
            {ptr_ld, stack_ld, work_ld, mulop_ld} = 4'hF;
            @(negedge clk);
            {ptr_ld, stack_ld, work_ld, mulop_ld} = 4'h0;
            chk(ptr, v);
            chk({stack, mulop}, {v[7:0], ~v[7:0]});
            rdchk(ADDR_PTR_HI, v[15:8]);
            chk(16'(flags[0]), 16'(^v[15:8]));
        end
        reset_dut();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule // mcu_core_sfr_registers_test

`default_nettype wire
